/* hw/planar_graphics_palette.v */
`timescale 1ns/1ps
`include "planar_graphics_palette_map.vh"
module planar_graphics_palette #(
    parameter [2:0] BOARD_REV = 3'h0   // arbitrary value
) (
    // clock and reset
    input  wire        clk_i,
    input  wire        arst_n_i,
    // processor memory cycle
    input  wire        mem_req_i,
    input  wire [19:0] mem_addr_i,
    input  wire        mem_we_i,
    input  wire [1:0]  mem_be_i,
    input  wire [15:0] mem_wdata_i,
    output reg         mem_wait_o,
    output reg         mem_ready_o,
    output reg  [15:0] mem_rdata_o,
    // processor i/o cycle
    input  wire        graphics_io_chip_select_i,
    input  wire        io_wr_i,
    input  wire        io_rd_i,
    input  wire [15:0] io_addr_i,
    input  wire [15:0] io_wdata_i,
    output reg  [15:0] io_rdata_o,
    output reg         io_rvalid_o,
    // straps
    input  wire [2:0]  plane_fitted_i,
    input  wire        board_type_i,
    // video timing and external text video
    input  wire        frame_start_i,
    input  wire        vid_active_i,
    input  wire        ext_video_i,
    input  wire        ext_intensity_i,
    // colour and monochrome outputs
    output reg         blue_o,
    output reg         green_o,
    output reg         red_o,
    output reg         intensity_o,
    output reg         mono_video_o,
    output reg         text_select_o
);

    // integer forms first, then cut to the counter widths on purpose
    localparam integer ACC_LOAD_I = `CPU_ACCESS_CYC - 1;
    localparam integer PIX_LAST_I = `PIX_DIV - 1;
    localparam [4:0]   ACC_LOAD   = ACC_LOAD_I[4:0];
    localparam [0:0]   PIX_LAST   = PIX_LAST_I[0:0];

    reg         rst_meta_reg;
    reg         rst_sync_reg;
    wire        rst_n;

    always @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    assign rst_n = rst_sync_reg;

    // straps caught on the first edge after release
    reg         strap_done_reg;
    reg  [2:0]  fitted_reg;
    reg         board_type_reg;

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            strap_done_reg <= 1'b0;
            fitted_reg     <= 3'h0;
            board_type_reg <= 1'b0;
        end else if (!strap_done_reg) begin
            strap_done_reg <= 1'b1;
            fitted_reg     <= plane_fitted_i;
            board_type_reg <= board_type_i;
        end
    end

    // i/o decode
    reg  [5:0]  ctrl_reg;
    wire        io_wr   = graphics_io_chip_select_i & io_wr_i;
    wire        io_rd   = graphics_io_chip_select_i & io_rd_i;
    wire        pal_hit = (io_addr_i[`IO_PAL_TAG_HI:`IO_PAL_TAG_LO] == `IO_PAL_TAG) &
                          ~io_addr_i[0];
    wire        pal_we  = io_wr & pal_hit;
    wire [3:0]  pal_idx = io_addr_i[`IO_PAL_IDX_HI:`IO_PAL_IDX_LO];
    wire [5:0]  status  = {1'b0, BOARD_REV, &fitted_reg, board_type_reg};

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg    <= `CTRL_RST;
            io_rdata_o  <= 16'h0000;
            io_rvalid_o <= 1'b0;
        end else begin
            if (io_wr && io_addr_i == `IO_CTRL_ADDR)
                ctrl_reg <= io_wdata_i[5:0];
            // palette and control are write-only, so only the status reads back
            io_rvalid_o <= io_rd;
            if (io_rd && io_addr_i == `IO_STATUS_ADDR)
                io_rdata_o <= {`STAT_PAD, status};
            else
                io_rdata_o <= 16'h0000;
        end
    end

    wire        disp_on  = ctrl_reg[`CTRL_DISP_BIT];
    wire        gfx_mode = ctrl_reg[`CTRL_GFX_BIT];
    // several select bits set means no plane answers
    wire [2:0]  sel_ok   = (ctrl_reg[2:0] == `SEL_P0 || ctrl_reg[2:0] == `SEL_P1 ||
                            ctrl_reg[2:0] == `SEL_P2) ? ctrl_reg[2:0] : 3'h0;

    // palette entries, reset so the outputs never carry unknowns
    wire [63:0] pal_flat;
    genvar e;
    generate
        for (e = 0; e < 16; e = e + 1) begin : g_pal
            reg [3:0] entry_reg;
            always @(posedge clk_i or negedge rst_n) begin
                if (!rst_n)
                    entry_reg <= `PAL_RST;
                else if (pal_we && pal_idx == e)
                    entry_reg <= io_wdata_i[3:0];
            end
            assign pal_flat[e*4 +: 4] = entry_reg;
        end
    endgenerate

    // pixel rate enable
    reg  [0:0]  pix_div_reg;
    wire        pix_en = (pix_div_reg == PIX_LAST);

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            pix_div_reg <= 1'b0;
        else
            pix_div_reg <= pix_en ? 1'b0 : pix_div_reg + 1'b1;
    end

    // display fetch: one word per plane, prefetched ahead of the shifter
    reg  [13:0] fetch_addr_reg;
    reg         fetch_pend_reg;
    reg  [3:0]  bit_cnt_reg;
    wire        fetch_go = fetch_pend_reg;
    wire        load_sh  = vid_active_i & pix_en & (bit_cnt_reg == 4'h0);

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            fetch_addr_reg <= `WORD_ZERO;
            fetch_pend_reg <= 1'b0;
            bit_cnt_reg    <= 4'h0;
        end else if (frame_start_i) begin
            fetch_addr_reg <= `WORD_ZERO;
            fetch_pend_reg <= 1'b1;
            bit_cnt_reg    <= 4'h0;
        end else begin
            if (vid_active_i && pix_en)
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (fetch_go) begin
                fetch_pend_reg <= 1'b0;
                if (fetch_addr_reg == `SCREEN_LAST)
                    fetch_addr_reg <= `WORD_ZERO;
                else
                    fetch_addr_reg <= fetch_addr_reg + `WORD_ONE;
            end else if (load_sh) begin
                fetch_pend_reg <= 1'b1;
            end
        end
    end

    // cpu access, paced and arbitrated against the fetch slot
    reg         busy_reg;
    reg  [4:0]  wait_cnt_reg;
    reg  [13:0] cpu_addr_reg;
    reg         cpu_we_reg;
    reg  [1:0]  cpu_be_reg;
    reg  [15:0] cpu_wdata_reg;
    reg         cpu_done_reg;
    wire        win_hit = (mem_addr_i[`WIN_TAG_HI:`WIN_TAG_LO] == `WIN_TAG);
    wire        take    = mem_req_i & win_hit & ~busy_reg;
    // fetch owns the memory in its cycle; the cpu simply waits one more
    wire        cpu_go  = busy_reg & (wait_cnt_reg == 5'h00) & ~fetch_go;

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            busy_reg      <= 1'b0;
            wait_cnt_reg  <= 5'h00;
            cpu_addr_reg  <= `WORD_ZERO;
            cpu_we_reg    <= 1'b0;
            cpu_be_reg    <= 2'h0;
            cpu_wdata_reg <= 16'h0000;
            cpu_done_reg  <= 1'b0;
            mem_wait_o    <= 1'b0;
        end else begin
            cpu_done_reg <= cpu_go;
            if (take) begin
                busy_reg      <= 1'b1;
                mem_wait_o    <= 1'b1;
                wait_cnt_reg  <= ACC_LOAD;
                // word address ignores a0; words are assumed even
                cpu_addr_reg  <= mem_addr_i[`WORD_HI:`WORD_LO];
                cpu_we_reg    <= mem_we_i;
                cpu_be_reg    <= mem_be_i;
                cpu_wdata_reg <= mem_wdata_i;
            end else if (cpu_go) begin
                busy_reg <= 1'b0;
            end else if (busy_reg && wait_cnt_reg != 5'h00) begin
                wait_cnt_reg <= wait_cnt_reg - 5'h01;
            end
            if (cpu_done_reg)
                mem_wait_o <= 1'b0;
        end
    end

    // planes: storage, cpu port and shifters
    wire [2:0]  plane_hit = sel_ok & fitted_reg;
    wire [2:0]  pix_bit;
    wire [47:0] cpu_rd_flat;
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_plane
            reg [15:0] mem [0:`PLANE_WORDS-1];
            reg [15:0] prefetch_reg;
            reg [15:0] shift_reg;
            reg [15:0] cpu_rd_reg;
            always @(posedge clk_i) begin
                if (cpu_go && cpu_we_reg && plane_hit[g]) begin
                    if (cpu_be_reg[0])
                        mem[cpu_addr_reg][7:0] <= cpu_wdata_reg[7:0];
                    if (cpu_be_reg[1])
                        mem[cpu_addr_reg][15:8] <= cpu_wdata_reg[15:8];
                end
            end
            always @(posedge clk_i or negedge rst_n) begin
                if (!rst_n) begin
                    prefetch_reg <= 16'h0000;
                    shift_reg    <= 16'h0000;
                    cpu_rd_reg   <= 16'h0000;
                end else begin
                    if (fetch_go)
                        prefetch_reg <= mem[fetch_addr_reg];
                    if (load_sh)
                        shift_reg <= prefetch_reg;
                    else if (vid_active_i && pix_en)
                        shift_reg <= {shift_reg[14:0], 1'b0};
                    if (cpu_go)
                        cpu_rd_reg <= plane_hit[g] ? mem[cpu_addr_reg] : 16'h0000;
                end
            end
            assign pix_bit[g] = shift_reg[15];
            assign cpu_rd_flat[g*16 +: 16] = cpu_rd_reg;
        end
    endgenerate

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mem_ready_o <= 1'b0;
            mem_rdata_o <= 16'h0000;
        end else begin
            mem_ready_o <= cpu_done_reg;
            if (cpu_done_reg)
                mem_rdata_o <= cpu_rd_flat[15:0] | cpu_rd_flat[31:16] | cpu_rd_flat[47:32];
        end
    end

    // palette lookup address
    reg  [3:0]  pal_addr;
    wire [2:0]  gfx_bits = pix_bit | ~fitted_reg;

    always @* begin
        pal_addr = `PAL_OFF_ADDR;
        if (!gfx_mode)
            pal_addr = {`PAL_HIGH, `PAL_HIGH, ext_intensity_i, ext_video_i};
        else if (!disp_on)
            pal_addr = `PAL_OFF_ADDR;
        else
            pal_addr = {`PAL_HIGH, gfx_bits};
    end

    wire [3:0]  colour = pal_flat[{pal_addr, 2'b00} +: 4];

    always @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            blue_o        <= 1'b0;
            green_o       <= 1'b0;
            red_o         <= 1'b0;
            intensity_o   <= 1'b0;
            mono_video_o  <= 1'b0;
            text_select_o <= 1'b0;
        end else begin
            blue_o        <= colour[`PAL_BLUE];
            green_o       <= colour[`PAL_GREEN];
            red_o         <= colour[`PAL_RED];
            intensity_o   <= colour[`PAL_INTENS];
            mono_video_o  <= vid_active_i & pix_bit[0] & fitted_reg[0];
            text_select_o <= gfx_mode;
        end
    end

endmodule

/* hw/planar_graphics_palette_map.vh */
// Summary of operation
// - graphics memory window starts at E0000H
// - one screen is 16,000 words per plane
// - three 16K-word planes share one address range
// - word and high or low byte transfers
// - cpu may access anytime, wait states pace it
// - msb is leftmost pixel, lsb rightmost
// - graphics lookup address planes 0-2, bit3 high
// - missing plane forces its address bit high
// - write-only palette, 16 even words from 0180H
// - palette stores d3-d0, upper bits ignored
// - entry bits drive blue, green, red, intensity
// - write-only 6-bit control at 01A0H
// - one-hot plane select, several deselect all
// - display off forces lookup address 08H in graphics mode
// - bit5 picks planes or external text video
// - text address: video, intensity, then ones
// - text/graphics select bit exported to main unit
// - monochrome output uses plane 0 only
// - status port read at I/O 0180H
`ifndef PLANAR_GRAPHICS_PALETTE_MAP_VH
`define PLANAR_GRAPHICS_PALETTE_MAP_VH

`define WIN_TAG         5'h1c
`define WIN_TAG_HI      19
`define WIN_TAG_LO      15
`define WORD_HI         14
`define WORD_LO         1
`define PLANE_WORDS     16384
`define SCREEN_LAST     14'h3e7f
`define WORD_ZERO       14'h0000
`define WORD_ONE        14'h0001

`define IO_PAL_TAG      11'h00c
`define IO_PAL_TAG_HI   15
`define IO_PAL_TAG_LO   5
`define IO_PAL_IDX_HI   4
`define IO_PAL_IDX_LO   1
`define IO_CTRL_ADDR    16'h01a0
`define IO_STATUS_ADDR  16'h0180

`define CTRL_RST        6'h00
`define CTRL_DISP_BIT   4
`define CTRL_GFX_BIT    5
`define SEL_P0          3'h1
`define SEL_P1          3'h2
`define SEL_P2          3'h4

`define PAL_RST         4'h0
`define PAL_OFF_ADDR    4'h8
`define PAL_HIGH        1'b1
`define PAL_BLUE        0
`define PAL_GREEN       1
`define PAL_RED         2
`define PAL_INTENS      3

`define STAT_PAD        10'h000

`define CLK_PERIOD_NS   40
`define CPU_ACCESS_NS   1000
`define CPU_ACCESS_CYC  ((`CPU_ACCESS_NS) / (`CLK_PERIOD_NS))
`define PIX_DIV         2

`endif

/* tb/pgp_checker.sv */
`timescale 1ns/1ps
module pgp_checker #(
    parameter [2:0] BOARD_REV = 3'h0
) (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        arst_n_i,
    // memory cycle
    input wire logic        mem_req_i,
    input wire logic [19:0] mem_addr_i,
    input wire logic        mem_wait_o,
    input wire logic        mem_ready_o,
    input wire logic [15:0] mem_rdata_o,
    // i/o cycle
    input wire logic        graphics_io_chip_select_i,
    input wire logic        io_wr_i,
    input wire logic        io_rd_i,
    input wire logic [15:0] io_addr_i,
    input wire logic [15:0] io_wdata_i,
    input wire logic [15:0] io_rdata_o,
    input wire logic        io_rvalid_o,
    // straps and video
    input wire logic [2:0]  plane_fitted_i,
    input wire logic        board_type_i,
    input wire logic        vid_active_i,
    input wire logic        mono_video_o,
    input wire logic        text_select_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_take;
        mem_req_i && mem_addr_i[19:15] == 5'h1c && !mem_wait_o && !mem_ready_o;
    endsequence
    sequence s_ior;
        graphics_io_chip_select_i && io_rd_i;
    endsequence
    // pacing: never answers early, never leaves the cpu hanging
    a_wait_raise: assert property (s_take |=> mem_wait_o) else $error("wait not raised");
    a_ready_bound: assert property (s_take |=> (!mem_ready_o)[*8] ##[10:40] mem_ready_o)
        else $error("ready out of window");
    a_ready_pulse: assert property (mem_ready_o |=> !mem_ready_o) else $error("ready too long");
    a_ready_wait: assert property (mem_ready_o |-> !mem_wait_o) else $error("wait with ready");
    a_rdata_hold: assert property (!mem_ready_o |-> $stable(mem_rdata_o))
        else $error("read data moved");
    a_rvalid_rd: assert property (s_ior |=> io_rvalid_o) else $error("no read answer");
    a_rvalid_only: assert property (!(graphics_io_chip_select_i && io_rd_i) |=> !io_rvalid_o)
        else $error("spurious read answer");
    a_status_val: assert property (s_ior and io_addr_i == 16'h0180 |=>
        io_rdata_o == {10'h000, 1'b0, BOARD_REV, &plane_fitted_i, board_type_i})
        else $error("bad status");
    a_other_read: assert property (s_ior and io_addr_i != 16'h0180 |=> io_rdata_o == 16'h0000)
        else $error("palette readable");
    a_mono_idle: assert property (!$past(vid_active_i) |-> !mono_video_o)
        else $error("mono outside display");
    a_text_sel: assert property (graphics_io_chip_select_i && io_wr_i && io_addr_i == 16'h01a0
        |=> ##1 text_select_o == $past(io_wdata_i[5], 2)) else $error("text select lost");
endmodule
bind planar_graphics_palette pgp_checker #(.BOARD_REV(BOARD_REV)) chk (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .mem_req_i(mem_req_i), .mem_addr_i(mem_addr_i),
    .mem_wait_o(mem_wait_o), .mem_ready_o(mem_ready_o), .mem_rdata_o(mem_rdata_o),
    .graphics_io_chip_select_i(graphics_io_chip_select_i), .io_wr_i(io_wr_i),
    .io_rd_i(io_rd_i), .io_addr_i(io_addr_i), .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o), .io_rvalid_o(io_rvalid_o), .plane_fitted_i(plane_fitted_i),
    .board_type_i(board_type_i), .vid_active_i(vid_active_i),
    .mono_video_o(mono_video_o), .text_select_o(text_select_o));

/* tb/host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model (
    // command from the bench
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [19:0] addr_i,
    input  wire logic        we_i,
    input  wire logic [1:0]  be_i,
    input  wire logic [15:0] wdata_i,
    // memory cycle towards the device
    input  wire logic        mem_ready_i,
    output logic             mem_req_o,
    output logic [19:0]      mem_addr_o,
    output logic             mem_we_o,
    output logic [1:0]       mem_be_o,
    output logic [15:0]      mem_wdata_o,
    output logic             busy_o
);
    initial {mem_req_o, mem_addr_o, mem_we_o, mem_be_o, mem_wdata_o, busy_o} = '0;
    always @(posedge clk_i) begin
        mem_req_o <= 1'b0;
        if (go_i && !busy_o) begin
            mem_req_o   <= 1'b1;
            // word cycles always start on an even byte
            mem_addr_o  <= {addr_i[19:1], addr_i[0] & (be_i != 2'b11)};
            mem_we_o    <= we_i;
            mem_be_o    <= be_i;
            mem_wdata_o <= wdata_i;
            busy_o      <= 1'b1;
        end else if (busy_o && mem_ready_i) begin
            // released lines change so stale values cannot pass
            mem_addr_o  <= ~mem_addr_o;
            mem_wdata_o <= ~mem_wdata_o;
            busy_o      <= 1'b0;
        end
    end
endmodule

/* tb/planar_graphics_palette_test.sv */
`timescale 1ns/1ps
module planar_graphics_palette_test;
    logic        clk = 1'b0, arst_n = 1'b0, go = 1'b0, we = 1'b0, busy;
    logic        cs = 1'b0, wr = 1'b0, rd = 1'b0, fs = 1'b0, act = 1'b0, xv = 1'b0, xi = 1'b0;
    logic [1:0]  be = 2'b11, mbe;
    logic [19:0] a = 20'h0_0000, ma;
    logic [15:0] d = 16'h0000, ia = 16'h0000, iw = 16'h0000, mwd, mrd, ird, dw;
    logic        req, mwe, mwait, mrdy, irv, blu, grn, red, ins, mono, tsel;
    logic [3:0]  pal [16];
    logic [16:0] qm [$], qi [$], x, y;
    int          miscompares = 0, check_count = 0;
    always #20 clk = ~clk;
    host_bus_model host (.clk_i(clk), .go_i(go), .addr_i(a), .we_i(we), .be_i(be),
        .wdata_i(d), .mem_ready_i(mrdy), .mem_req_o(req), .mem_addr_o(ma), .mem_we_o(mwe),
        .mem_be_o(mbe), .mem_wdata_o(mwd), .busy_o(busy));
    planar_graphics_palette dut (.clk_i(clk), .arst_n_i(arst_n), .mem_req_i(req),
        .mem_addr_i(ma), .mem_we_i(mwe), .mem_be_i(mbe), .mem_wdata_i(mwd),
        .mem_wait_o(mwait), .mem_ready_o(mrdy), .mem_rdata_o(mrd),
        .graphics_io_chip_select_i(cs), .io_wr_i(wr), .io_rd_i(rd), .io_addr_i(ia),
        .io_wdata_i(iw), .io_rdata_o(ird), .io_rvalid_o(irv), .plane_fitted_i(3'h7),
        .board_type_i(1'b1), .frame_start_i(fs), .vid_active_i(act), .ext_video_i(xv),
        .ext_intensity_i(xi), .blue_o(blu), .green_o(grn), .red_o(red),
        .intensity_o(ins), .mono_video_o(mono), .text_select_o(tsel));
    task cmp_bus(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %0t bus got %h exp %h", $time, got, exp);
        end
    endtask
    task cmp_col(input logic [3:0] exp);
        check_count++;
        if ({ins, red, grn, blu} !== exp) begin
            miscompares++;
            $display("mismatch %0t colour got %h exp %h", $time, {ins, red, grn, blu}, exp);
        end
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task io(input logic w, input logic [15:0] ad, input logic [15:0] dt, input logic [15:0] ex);
        if (!w) qi.push_back({1'b1, ex});
        @(posedge clk);
        cs <= 1'b1; wr <= w; rd <= !w; ia <= ad; iw <= dt;
        @(posedge clk);
        cs <= 1'b0; wr <= 1'b0; rd <= 1'b0;
    endtask
    task ctrl(input logic [5:0] v);
        io(1'b1, 16'h01a0, {10'h000, v}, 16'h0000);
    endtask
    task mem(input logic [19:0] ad, input logic w, input logic [1:0] b,
             input logic [15:0] dt, input logic [15:0] ex);
        int n;
        qm.push_back({!w, ex});
        @(posedge clk);
        go <= 1'b1; a <= ad; we <= w; be <= b; d <= dt;
        @(posedge clk);
        go <= 1'b0;
        @(negedge clk);
        for (n = 0; n < 100 && busy !== 1'b0; n++) @(negedge clk);
        if (n == 100) begin
            miscompares++;
            end_sim;
        end
    endtask
    task wcol(input logic [3:0] e, input int lim);
        int n;
        for (n = 0; n < lim && {ins, red, grn, blu} !== e; n++) @(negedge clk);
        cmp_col(e);
        if (n == lim) end_sim;
    endtask
    // results arrive in request order, so one queue per bus suffices
    always @(negedge clk) begin
        if (irv === 1'b1) begin
            x = qi.size() > 0 ? qi.pop_front() : 17'h1_ffff;
            cmp_bus(ird, x[15:0]);
        end
        if (mrdy === 1'b1) begin
            y = qm.size() > 0 ? qm.pop_front() : 17'h1_ffff;
            if (y[16]) cmp_bus(mrd, y[15:0]);
        end
    end
    initial begin
        void'($urandom(21));
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        repeat (6) @(posedge clk);
        io(1'b0, 16'h0180, 16'h0000, 16'h0003);
        io(1'b0, 16'h0182, 16'h0000, 16'h0000);
        $display("test status done");
        // loaded while video is blanked
        for (int i = 0; i < 16; i++) begin
            pal[i] = 4'($urandom);
            if (i == 9) pal[i] = pal[8] ^ 4'h5;
            io(1'b1, 16'h0180 + 16'(2 * i), {12'($urandom), pal[i]}, 16'h0000);
        end
        io(1'b1, 16'h0191, {12'h000, ~pal[8]}, 16'h0000);
        ctrl(6'h20);
        wcol(pal[8], 8);
        cmp_bus({15'h0000, tsel}, 16'h0001);
        ctrl(6'h00);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            xv <= i[0];
            xi <= i[1];
            wcol(pal[{2'b11, 2'(i)}], 8);
        end
        cmp_bus({15'h0000, tsel}, 16'h0000);
        $display("test palette done");
        ctrl(6'h21);
        dw = 16'($urandom);
        mem(20'he_0000, 1'b1, 2'b11, dw, 16'h0000);
        mem(20'he_0000, 1'b0, 2'b11, 16'h0000, dw);
        mem(20'he_0001, 1'b1, 2'b10, 16'h3cc3, 16'h0000);
        mem(20'he_0000, 1'b0, 2'b11, 16'h0000, {8'h3c, dw[7:0]});
        mem(20'he_7cfe, 1'b1, 2'b11, ~dw, 16'h0000);
        mem(20'he_7cfe, 1'b0, 2'b11, 16'h0000, ~dw);
        ctrl(6'h22);
        mem(20'he_0000, 1'b1, 2'b11, 16'h0000, 16'h0000);
        ctrl(6'h24);
        mem(20'he_0000, 1'b1, 2'b11, 16'h0000, 16'h0000);
        ctrl(6'h23);
        mem(20'he_0000, 1'b0, 2'b11, 16'h0000, 16'h0000);
        ctrl(6'h21);
        mem(20'he_0000, 1'b0, 2'b11, 16'h0000, {8'h3c, dw[7:0]});
        mem(20'he_0000, 1'b1, 2'b11, 16'h8000, 16'h0000);
        $display("test memory done");
        ctrl(6'h30);
        @(posedge clk);
        fs <= 1'b1;
        act <= 1'b1;
        @(posedge clk);
        fs <= 1'b0;
        wcol(pal[9], 200);
        cmp_bus({15'h0000, mono}, 16'h0001);
        wcol(pal[8], 8);
        cmp_bus({15'h0000, mono}, 16'h0000);
        @(posedge clk);
        act <= 1'b0;
        $display("test display done");
        repeat (4) @(posedge clk);
        end_sim;
    end
endmodule
